// ==== design/pcdc_clk_div.sv ====
// power-of-two divider that emits one enable tick per divided period
`timescale 1ns/10ps
`default_nettype none
module pcdc_clk_div (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [3:0] div_exp,
  output logic tick
);
  import pcdc_pkg::*;

  logic [7:0] count_ff;
  logic tick_ff;
  logic [8:0] span;
  logic [7:0] limit;

  // period is two to the power div_exp cycles for div_exp up to 8; larger values give 256 cycles
  assign span = 9'h001 << div_exp;
  assign limit = 8'(span - 9'h001);
  assign tick = tick_ff;

  // a stopped source holds the count at zero so restarts begin a clean period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count_ff <= 8'h00;
        tick_ff <= 1'b0;
      end else if (count_ff >= limit) begin
        count_ff <= 8'h00;
        tick_ff <= 1'b1;
      end else begin
        count_ff <= count_ff + 8'h01;
        tick_ff <= 1'b0;
      end
    end
  end

endmodule // pcdc_clk_div
`default_nettype wire

// ==== design/pcdc_clkout.sv ====
// first clock-output pin with glitch-free drive-mode switching
`timescale 1ns/10ps
`default_nettype none
module pcdc_clkout (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic crystal_in,
  input wire logic locked,
  input wire logic [1:0] mode_req,
  output logic clock_out_one,
  output logic [1:0] drive_mode
);
  import pcdc_pkg::*;

  logic [1:0] mode_ff;
  logic pin_ff;
  logic safe;

  assign clock_out_one = pin_ff;
  assign drive_mode = mode_ff;

  // safe switch point
  // switching only while the pin already sits high (or is held low while
  // unlocked) means no shortened high or low phase ever reaches the pin
  assign safe = crystal_in || !locked;

  // requested mode is adopted at the next safe moment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= PCDC_DRIVE_OFF;
    end else if (clk_en && safe) begin
      mode_ff <= mode_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ff <= 1'b1;
    end else if (clk_en) begin
      pin_ff <= (mode_ff == PCDC_DRIVE_OFF) ? 1'b1 : (locked && crystal_in);
    end
  end

endmodule // pcdc_clkout
`default_nettype wire

// ==== design/pcdc_pkg.sv ====
// constants, register map and packed carriers for the pll and clock divider control block
package pcdc_pkg;

  // ****************************************
  // register map, byte addresses on the bus
  // ****************************************
  localparam logic [3:0] PCDC_OFF_PLL = 4'h0;
  localparam logic [3:0] PCDC_OFF_DIV = 4'h4;
  localparam logic [3:0] PCDC_OFF_CLKOUT = 4'h8;
  localparam logic [3:0] PCDC_OFF_STATUS = 4'hc;

  // ****************************************
  // field encodings and reset values
  // ****************************************
  localparam logic [1:0] PCDC_DRIVE_FULL = 2'h0;
  localparam logic [1:0] PCDC_DRIVE_OFF = 2'h3;
  localparam logic [1:0] PCDC_PINS_RESERVED = 2'h0;
  localparam logic [1:0] PCDC_PINS_QUIET_OUT = 2'h1;
  localparam logic [1:0] PCDC_PINS_PRESCALE = 2'h3;
  localparam logic [11:0] PCDC_MF_LOW = 12'h000;
  localparam logic [11:0] PCDC_MF_HIGH = 12'h190;
  localparam logic [2:0] PCDC_IRQ_NEVER = 3'h7;
  localparam logic [2:0] PCDC_HIGH_RESERVED = 3'h7;
  localparam logic [2:0] PCDC_LOW_RESERVED = 3'h6;
  localparam logic [2:0] PCDC_LOW_DIV256 = 3'h7;
  localparam logic [15:0] PCDC_DIV_RESET = 16'h0000;
  localparam int PCDC_CLKOUT_LOCK_BIT = 7;

  // ****************************************
  // timing
  // ****************************************
  localparam int PCDC_CLK_PERIOD_NS = 5;
  localparam int PCDC_RELOCK_NS = 2000;
  localparam int PCDC_RELOCK_CYCLES = (PCDC_RELOCK_NS + PCDC_CLK_PERIOD_NS - 1) / PCDC_CLK_PERIOD_NS;
  localparam logic [9:0] PCDC_RELOCK_LAST = 10'(PCDC_RELOCK_CYCLES - 1);

  // ****************************************
  // packed register layouts, msb first
  // ****************************************
  typedef struct packed {
    logic pll_on_bit;
    logic pll_reg_lock;
    logic input_prescale_on;
    logic stop_clock_source;
    logic [11:0] pll_multiplier;
  } pcdc_pll_t;

  typedef struct packed {
    logic divider_reg_lock;
    logic [1:0] sync_clock_divide;
    logic [1:0] baud_clock_divide;
    logic [2:0] irq_speedup_level;
    logic coproc_speedup_on;
    logic [2:0] low_speed_divide;
    logic [2:0] high_speed_divide;
    logic low_speed_select;
  } pcdc_div_t;

  typedef enum logic [1:0] {PCDC_PLL_IDLE, PCDC_PLL_ACQUIRE, PCDC_PLL_LOCKED} pcdc_pll_state_t;

endpackage

// ==== design/pcdc_top.sv ====
// pll and clock divider control block with its ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none
module pcdc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] mode_clock_pins,
  input wire logic crystal_in,
  input wire logic low_power_stop_op,
  input wire logic coproc_busy,
  input wire logic [2:0] irq_level,
  output logic pll_locked,
  output logic [12:0] pll_multiplier_value,
  output logic pll_ref_div128,
  output logic pll_power_down,
  output logic integration_from_crystal,
  output logic integration_div256,
  output logic system_at_high,
  output logic system_clock_tick,
  output logic sync_clock_tick,
  output logic baud_gen_tick,
  output logic clock_out_one,
  output logic [1:0] clock_out_one_drive
);
  import pcdc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  pcdc_pll_t pll_ff, nxt_pll;
  pcdc_div_t div_ff, nxt_div;
  logic [1:0] clkout_mode_ff, nxt_clkout_mode;
  logic clkout_lock_ff, nxt_clkout_lock;
  logic [1:0] pins_ff;
  logic strap_done_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic [3:0] wr_addr_ff;
  logic wr_priv_ff;
  logic addr_take;
  logic wr_pll, wr_div, wr_clkout;
  logic pll_restart;
  pcdc_pll_state_t state_ff;
  logic [9:0] relock_cnt_ff;
  logic pll_locked_ff, pll_ref_div128_ff, pll_power_down_ff;
  logic integration_from_crystal_ff, integration_div256_ff, system_at_high_ff;
  logic [12:0] pll_multiplier_value_ff;
  logic pd_req, speedup, use_high;
  logic [3:0] sys_exp, sync_exp, baud_exp;
  logic [31:0] rd_mux;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign addr_take = hsel && htrans[1] && hready;

  // address phase is latched; the write lands at the end of its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 4'h0;
      wr_priv_ff <= 1'b0;
    end else if (clk_en) begin
      wr_pend_ff <= addr_take && hwrite;
      wr_addr_ff <= haddr[3:0];
      wr_priv_ff <= hprot[1];
    end
  end

  // never inserts wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b0;
    end else if (clk_en) begin
      hreadyout_ff <= 1'b1;
    end
  end

  // supervisor-only writes
  // user-mode writes are dropped silently, the bus answer stays okay
  assign wr_pll = wr_pend_ff && wr_priv_ff && (wr_addr_ff == PCDC_OFF_PLL);
  assign wr_div = wr_pend_ff && wr_priv_ff && (wr_addr_ff == PCDC_OFF_DIV);
  assign wr_clkout = wr_pend_ff && wr_priv_ff && (wr_addr_ff == PCDC_OFF_CLKOUT);

  // read data of the three writable registers comes from next-state values so a read right behind a write sees it
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[3:0])
      PCDC_OFF_PLL: rd_mux = {16'h0000, nxt_pll};
      PCDC_OFF_DIV: rd_mux = {16'h0000, nxt_div};
      PCDC_OFF_CLKOUT: rd_mux = {24'h000000, nxt_clkout_lock, 5'h00, nxt_clkout_mode};
      PCDC_OFF_STATUS: rd_mux = {28'h0000000, use_high, pins_ff, pll_locked_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      hrdata_ff <= (addr_take && !hwrite && hprot[1]) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // register next values
  // ****************************************
  // strap pll control from the clock-mode pins
  // prescale and multiplier share one write
  always_comb begin
    nxt_pll = pll_ff;
    if (!strap_done_ff) begin
      nxt_pll.pll_on_bit = (mode_clock_pins != PCDC_PINS_RESERVED);
      nxt_pll.pll_reg_lock = 1'b0;
      nxt_pll.input_prescale_on = (mode_clock_pins == PCDC_PINS_PRESCALE);
      nxt_pll.stop_clock_source = 1'b0;
      nxt_pll.pll_multiplier = mode_clock_pins[1] ? PCDC_MF_HIGH : PCDC_MF_LOW;
    end else if (wr_pll && !pll_ff.pll_reg_lock) begin
      nxt_pll = pcdc_pll_t'(hwdata[15:0]);
    end
  end

  always_comb begin
    nxt_div = div_ff;
    if (!strap_done_ff) begin
      nxt_div = pcdc_div_t'(PCDC_DIV_RESET);
    end else if (wr_div && !div_ff.divider_reg_lock) begin
      nxt_div = pcdc_div_t'(hwdata[15:0]);
    end
  end

  // clock-output control, with its own write protect
  always_comb begin
    nxt_clkout_mode = clkout_mode_ff;
    nxt_clkout_lock = clkout_lock_ff;
    if (!strap_done_ff) begin
      nxt_clkout_mode = (mode_clock_pins == PCDC_PINS_QUIET_OUT) ? PCDC_DRIVE_OFF : PCDC_DRIVE_FULL;
      nxt_clkout_lock = 1'b0;
    end else if (wr_clkout && !clkout_lock_ff) begin
      nxt_clkout_mode = hwdata[1:0];
      nxt_clkout_lock = hwdata[PCDC_CLKOUT_LOCK_BIT];
    end
  end

  // ****************************************
  // register storage
  // ****************************************
  // strap pins are caught on the first enabled edge after reset release,
  // never under the asynchronous reset itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_ff <= 1'b0;
      pins_ff <= 2'h0;
    end else if (clk_en && !strap_done_ff) begin
      strap_done_ff <= 1'b1;
      pins_ff <= mode_clock_pins;
    end
  end

  // pll control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_ff <= '0;
    end else if (clk_en) begin
      pll_ff <= nxt_pll;
    end
  end

  // divider control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= pcdc_div_t'(PCDC_DIV_RESET);
    end else if (clk_en) begin
      div_ff <= nxt_div;
    end
  end

  // clock-output control register; quiet until the strap is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clkout_mode_ff <= PCDC_DRIVE_OFF;
      clkout_lock_ff <= 1'b0;
    end else if (clk_en) begin
      clkout_mode_ff <= nxt_clkout_mode;
      clkout_lock_ff <= nxt_clkout_lock;
    end
  end

  // ****************************************
  // pll lock tracking
  // ****************************************
  // multiplier change drops lock
  // a reference change through the prescaler also forces a relock;
  // divider writes never touch this path
  assign pll_restart = strap_done_ff
                       && ((nxt_pll.pll_multiplier != pll_ff.pll_multiplier)
                           || (nxt_pll.input_prescale_on != pll_ff.input_prescale_on));

  assign pd_req = low_power_stop_op && !pll_ff.stop_clock_source;

  // acquisition is modelled as a fixed relock time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= PCDC_PLL_IDLE;
      relock_cnt_ff <= 10'h000;
    end else if (clk_en) begin
      unique case (state_ff)
        PCDC_PLL_IDLE: begin
          relock_cnt_ff <= 10'h000;
          if (strap_done_ff && pll_ff.pll_on_bit && !pd_req) begin
            state_ff <= PCDC_PLL_ACQUIRE;
          end
        end
        PCDC_PLL_ACQUIRE: begin
          if (!pll_ff.pll_on_bit || pd_req) begin
            state_ff <= PCDC_PLL_IDLE;
          end else if (pll_restart) begin
            relock_cnt_ff <= 10'h000;
          end else if (relock_cnt_ff == PCDC_RELOCK_LAST) begin
            state_ff <= PCDC_PLL_LOCKED;
          end else begin
            relock_cnt_ff <= relock_cnt_ff + 10'h001;
          end
        end
        PCDC_PLL_LOCKED: begin
          relock_cnt_ff <= 10'h000;
          if (!pll_ff.pll_on_bit || pd_req) begin
            state_ff <= PCDC_PLL_IDLE;
          end else if (pll_restart) begin
            state_ff <= PCDC_PLL_ACQUIRE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  // multiplier is field plus one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_locked_ff <= 1'b0;
      pll_multiplier_value_ff <= 13'h0001;
      pll_ref_div128_ff <= 1'b0;
      pll_power_down_ff <= 1'b0;
      integration_from_crystal_ff <= 1'b0;
      integration_div256_ff <= 1'b0;
    end else if (clk_en) begin
      pll_locked_ff <= (state_ff == PCDC_PLL_LOCKED) && !pll_restart;
      pll_multiplier_value_ff <= {1'b0, pll_ff.pll_multiplier} + 13'h0001;
      pll_ref_div128_ff <= pll_ff.input_prescale_on;
      pll_power_down_ff <= pd_req;
      integration_from_crystal_ff <= pd_req;
      integration_div256_ff <= pd_req && pll_ff.input_prescale_on;
    end
  end

  assign pll_locked = pll_locked_ff;
  assign pll_multiplier_value = pll_multiplier_value_ff;
  assign pll_ref_div128 = pll_ref_div128_ff;
  assign pll_power_down = pll_power_down_ff;
  assign integration_from_crystal = integration_from_crystal_ff;
  assign integration_div256 = integration_div256_ff;
  assign system_at_high = system_at_high_ff;

  // ****************************************
  // system clock selection
  // ****************************************
  // interrupt and coprocessor speed-up
  assign speedup = (div_ff.coproc_speedup_on && coproc_busy)
                   || ((div_ff.irq_speedup_level != PCDC_IRQ_NEVER)
                       && (irq_level > div_ff.irq_speedup_level));
  assign use_high = !div_ff.low_speed_select || speedup;

  // system clock exponents, high and low speed
  // reserved codes run at fixed rates: high code 7 at divide by 64, low code 6 at divide by 128
  always_comb begin
    sys_exp = 4'h0;
    if (use_high) begin
      sys_exp = (div_ff.high_speed_divide == PCDC_HIGH_RESERVED) ? 4'h6
                : {1'b0, div_ff.high_speed_divide};
    end else if (div_ff.low_speed_divide == PCDC_LOW_DIV256) begin
      sys_exp = 4'h8;
    end else if (div_ff.low_speed_divide == PCDC_LOW_RESERVED) begin
      sys_exp = 4'h7;
    end else begin
      sys_exp = {1'b0, div_ff.low_speed_divide} + 4'h1;
    end
  end

  // sync divide by four per code
  // baud divide by four per code
  assign sync_exp = {1'b0, div_ff.sync_clock_divide, 1'b0};
  assign baud_exp = {1'b0, div_ff.baud_clock_divide, 1'b0};

  // which divider is in force, for software and the system
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_at_high_ff <= 1'b1;
    end else if (clk_en) begin
      system_at_high_ff <= use_high;
    end
  end

  // ****************************************
  // derived clock enables and clock-out pin
  // ****************************************
  // derived clocks stop unlocked
  pcdc_clk_div u_sys_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .run(pll_locked_ff),
    .div_exp(sys_exp),
    .tick(system_clock_tick)
  );

  pcdc_clk_div u_sync_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .run(pll_locked_ff),
    .div_exp(sync_exp),
    .tick(sync_clock_tick)
  );

  pcdc_clk_div u_baud_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .run(pll_locked_ff),
    .div_exp(baud_exp),
    .tick(baud_gen_tick)
  );

  pcdc_clkout u_clkout (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .crystal_in(crystal_in),
    .locked(pll_locked_ff),
    .mode_req(clkout_mode_ff),
    .clock_out_one(clock_out_one),
    .drive_mode(clock_out_one_drive)
  );

endmodule // pcdc_top
`default_nettype wire

// ==== tb/pcdc_chk.sv ====
// port assertions for the pll and clock divider control block
`timescale 1ns/10ps
`default_nettype none
module pcdc_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic crystal_in,
  input wire logic pll_locked,
  input wire logic [12:0] pll_multiplier_value,
  input wire logic pll_ref_div128,
  input wire logic pll_power_down,
  input wire logic integration_from_crystal,
  input wire logic integration_div256,
  input wire logic system_clock_tick,
  input wire logic sync_clock_tick,
  input wire logic baud_gen_tick,
  input wire logic clock_out_one,
  input wire logic [1:0] clock_out_one_drive
);
  // ****************************************
  // output relations
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // two-cycle drive guards absorb the one-cycle lag of the pin flop
  chk_bus_ready: assert property ($past(hresetn) |-> hreadyout)
    else $error("ready dropped");
  chk_resp_okay: assert property (!hresp)
    else $error("error response");
  chk_off_high: assert property (clock_out_one_drive == 2'h3 &&
    $past(clock_out_one_drive) == 2'h3 |-> clock_out_one) else $error("off pin not high");
  chk_out_low: assert property (clock_out_one_drive != 2'h3 &&
    $past(clock_out_one_drive) != 2'h3 && !pll_locked && !$past(pll_locked) |->
    !clock_out_one) else $error("pin not low while unlocked");
  chk_out_follow: assert property (clock_out_one_drive != 2'h3 &&
    $past(clock_out_one_drive) != 2'h3 && pll_locked && $past(pll_locked) |->
    clock_out_one == $past(crystal_in)) else $error("pin not following crystal");
  chk_tick_stop: assert property (!pll_locked && !$past(pll_locked) |->
    !(system_clock_tick | sync_clock_tick | baud_gen_tick)) else $error("tick unlocked");
  chk_stop_source: assert property (pll_power_down == integration_from_crystal)
    else $error("stop source mismatch");
  chk_div256_src: assert property (integration_div256 |-> pll_power_down &&
    pll_ref_div128) else $error("bad crystal divide");
  chk_stop_unlock: assert property (pll_power_down [*3] |-> !pll_locked)
    else $error("locked while powered down");
  chk_mult_range: assert property (pll_multiplier_value inside {[13'h1:13'h1000]})
    else $error("multiplier out of range");
  chk_relock_hold: assert property ($fell(pll_locked) |-> !pll_locked [*8])
    else $error("relocked too soon");
  cover property ($fell(pll_locked));
  cover property (integration_div256);
  cover property (pll_locked && sync_clock_tick);
endmodule // pcdc_chk
bind pcdc_top pcdc_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .crystal_in(crystal_in), .pll_locked(pll_locked),
  .pll_multiplier_value(pll_multiplier_value), .pll_ref_div128(pll_ref_div128),
  .pll_power_down(pll_power_down), .integration_from_crystal(integration_from_crystal),
  .integration_div256(integration_div256), .system_clock_tick(system_clock_tick),
  .sync_clock_tick(sync_clock_tick), .baud_gen_tick(baud_gen_tick),
  .clock_out_one(clock_out_one), .clock_out_one_drive(clock_out_one_drive)
);
`default_nettype wire

// ==== tb/pcdc_tb.sv ====
// self-checking bench for the pll and clock divider control block
`timescale 1ns/10ps
`default_nettype none
module pcdc_tb;
  import pcdc_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [3:0] hprot = 4'h3;
  logic [31:0] hwdata = 0;
  logic [1:0] mode_clock_pins = 0;
  logic crystal_in = 0;
  logic low_power_stop_op = 0;
  logic coproc_busy = 0;
  logic [2:0] irq_level = 0;
  logic clk_en = 1'b1;
  wire hreadyout, hresp, pll_locked, pll_ref_div128, pll_power_down;
  wire integration_from_crystal, integration_div256, system_at_high;
  wire system_clock_tick, sync_clock_tick, baud_gen_tick, clock_out_one;
  wire [31:0] hrdata;
  wire [12:0] pll_multiplier_value;
  wire [1:0] clock_out_one_drive;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  // the bench drives the clock enable so a freeze can be exercised
  pcdc_top dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hprot(hprot), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mode_clock_pins(mode_clock_pins), .crystal_in(crystal_in),
    .low_power_stop_op(low_power_stop_op), .coproc_busy(coproc_busy),
    .irq_level(irq_level), .pll_locked(pll_locked),
    .pll_multiplier_value(pll_multiplier_value), .pll_ref_div128(pll_ref_div128),
    .pll_power_down(pll_power_down), .integration_from_crystal(integration_from_crystal),
    .integration_div256(integration_div256), .system_at_high(system_at_high),
    .system_clock_tick(system_clock_tick), .sync_clock_tick(sync_clock_tick),
    .baud_gen_tick(baud_gen_tick), .clock_out_one(clock_out_one),
    .clock_out_one_drive(clock_out_one_drive)
  );
  always #2.5 hclk = ~hclk;
  // crystal stand-in, synchronous to the bus clock
  always @(posedge hclk) crystal_in <= ~crystal_in;
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task close_out;
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // waits as long as the slave needs; only the hang guard ends a stuck wait
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 16'h0, q);
    chk(q, e);
  endtask
  task automatic rst(input logic [1:0] p);
    hresetn <= 1'b0;
    mode_clock_pins <= p;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic wlock;
    int n;
    n = 0;
    while (pll_locked !== 1'b1 && n < 900) begin
      @(posedge hclk);
      n++;
    end
    chk(pll_locked, 1'b1);
  endtask
  // settle past any divider restart, then count ticks over 256 cycles
  task automatic count(output int ns, output int nb, output int nh);
    ns = 0;
    nb = 0;
    nh = 0;
    repeat (260) @(posedge hclk);
    repeat (256) begin
      @(posedge hclk);
      ns += sync_clock_tick;
      nb += baud_gen_tick;
      nh += system_clock_tick;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [15:0] e;
    for (int p = 0; p < 4; p++) begin
      rst(p[1:0]);
      e = {p != 0, 1'b0, p == 3, 1'b0, p[1] ? PCDC_MF_HIGH : PCDC_MF_LOW};
      rd(PCDC_OFF_PLL, e);
      rd(PCDC_OFF_DIV, PCDC_DIV_RESET);
      chk(pll_multiplier_value, e[11:0] + 13'h1);
      chk(pll_ref_div128, p == 3);
      chk(clock_out_one_drive, p == 1 ? 2'h3 : 2'h0);
      if (p == 1) chk(clock_out_one, 1'b1);
      low_power_stop_op <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({pll_power_down, integration_from_crystal, integration_div256}, {2'h3, p == 3});
      low_power_stop_op <= 1'b0;
    end
  endtask
  task automatic t_lock;
    wlock();
    wr(PCDC_OFF_PLL, 16'h80ff);
    repeat (2) @(posedge hclk);
    chk(pll_locked, 1'b0);
    chk(pll_multiplier_value, 13'h100);
    chk(pll_ref_div128, 1'b0);
    // a frozen block must not finish its relock count
    clk_en <= 1'b0;
    repeat (500) @(posedge hclk);
    chk(pll_locked, 1'b0);
    clk_en <= 1'b1;
    wlock();
    wr(PCDC_OFF_PLL, 16'h8fff);
    repeat (2) @(posedge hclk);
    chk(pll_multiplier_value, 13'h1000);
    wlock();
    // stop with the source bit set keeps the vco and lock
    wr(PCDC_OFF_PLL, 16'h9fff);
    low_power_stop_op <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({pll_power_down, integration_from_crystal, pll_locked}, 3'h1);
    low_power_stop_op <= 1'b0;
    wr(PCDC_OFF_PLL, 16'h8fff);
  endtask
  task automatic t_drive;
    // second output is not driven here, so any first-output strength fits one buffer
    for (int m = 3; m >= 0; m--) begin
      wr(PCDC_OFF_CLKOUT, 16'(m));
      repeat (4) @(posedge hclk);
      chk(clock_out_one_drive, m[1:0]);
    end
  endtask
  task automatic t_div;
    int ns, nb, nh;
    for (int c = 0; c < 4; c++) begin
      wr(PCDC_OFF_DIV, 16'((c << 13) | ((3 - c) << 11) | (c << 1)));
      count(ns, nb, nh);
      chk(ns, 256 >> (2 * c));
      chk(nb, 256 >> (6 - 2 * c));
      chk(nh, 256 >> c);
      chk(pll_locked, 1'b1);
    end
    // last pass uses the reserved low code, which runs at divide by 128
    for (int k = 0; k < 3; k++) begin
      wr(PCDC_OFF_DIV, k == 0 ? 16'h0071 : (k == 1 ? 16'h0001 : 16'h0061));
      count(ns, nb, nh);
      chk(nh, k == 0 ? 1 : (k == 1 ? 128 : 2));
      chk(system_at_high, 1'b0);
    end
  endtask
  task automatic sp(input logic [7:0] lo, input logic [2:0] t, input logic [2:0] l,
                    input logic b, input logic e);
    wr(PCDC_OFF_DIV, {5'h0, t, lo});
    irq_level <= l;
    coproc_busy <= b;
    repeat (4) @(posedge hclk);
    chk(system_at_high, e);
  endtask
  task automatic t_prot;
    wr(PCDC_OFF_DIV, 16'h0002);
    hprot <= 4'h1;
    wr(PCDC_OFF_DIV, 16'h1234);
    rd(PCDC_OFF_DIV, 32'h0);
    hprot <= 4'h3;
    rd(PCDC_OFF_DIV, 32'h2);
    wr(PCDC_OFF_DIV, 16'h8004);
    wr(PCDC_OFF_DIV, 16'h0006);
    rd(PCDC_OFF_DIV, 32'h8004);
    wr(PCDC_OFF_PLL, 16'hcfff);
    wr(PCDC_OFF_PLL, 16'h8000);
    rd(PCDC_OFF_PLL, 32'hcfff);
    chk(pll_locked, 1'b1);
    wr(PCDC_OFF_STATUS, 16'hffff);
    rd(PCDC_OFF_STATUS, 32'hf);
  endtask
  initial begin
    t_reset();
    t_lock();
    t_drive();
    t_div();
    sp(8'h81, 3'h3, 3'h3, 1'b0, 1'b0);
    sp(8'h81, 3'h3, 3'h4, 1'b0, 1'b1);
    sp(8'h81, 3'h7, 3'h7, 1'b0, 1'b0);
    sp(8'h81, 3'h7, 3'h0, 1'b1, 1'b1);
    sp(8'h01, 3'h7, 3'h0, 1'b1, 1'b0);
    sp(8'h01, 3'h7, 3'h0, 1'b0, 1'b0);
    t_prot();
    close_out();
  end
endmodule // pcdc_tb
`default_nettype wire
